// ===== cpm_pkg.sv
// Constants shared by the codec pin-mux block
package cpm_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] CPM_ADDR_CFG_TWO = 8'h11;
    localparam logic [7:0] CPM_ADDR_CFG_THREE = 8'h12;
    localparam logic [7:0] CPM_ADDR_CFG_FOUR = 8'h13;
    localparam logic [7:0] CPM_ADDR_CFG_FIVE = 8'h14;
    localparam logic [7:0] CPM_ADDR_CFG_SIX = 8'h15;
    // ==========================================================
    // Reset values and writable masks
    localparam logic [7:0] CPM_RST_CFG_TWO = 8'h80;
    localparam logic [7:0] CPM_RST_CFG_THREE = 8'h00;
    localparam logic [7:0] CPM_RST_CFG_FOUR = 8'h00;
    localparam logic [7:0] CPM_RST_CFG_FIVE = 8'h00;
    localparam logic [7:0] CPM_RST_CFG_SIX = 8'h00;
    localparam logic [7:0] CPM_WMASK_CFG_TWO = 8'hFE;
    localparam logic [7:0] CPM_WMASK_CFG_THREE = 8'hFC;
    localparam logic [7:0] CPM_WMASK_CFG_FOUR = 8'hFF;
    localparam logic [7:0] CPM_WMASK_CFG_FIVE = 8'hFF;
    localparam logic [7:0] CPM_WMASK_CFG_SIX = 8'hF0;
    // ==========================================================
    // Field positions (low bit of each field)
    localparam int CPM_POS_PRI_IN_EN = 7;
    localparam int CPM_POS_SEC_FSYNC = 4;
    localparam int CPM_POS_SEC_BCLK = 1;
    localparam int CPM_POS_SEC_IN1 = 5;
    localparam int CPM_POS_SEC_IN2 = 2;
    localparam int CPM_POS_REC1_DIG = 7;
    localparam int CPM_POS_REC2_DIG = 6;
    localparam int CPM_POS_PAIR1_EDGE = 5;
    localparam int CPM_POS_PAIR2_EDGE = 4;
    localparam int CPM_POS_PAIR1_PIN = 2;
    localparam int CPM_POS_PAIR2_PIN = 0;
    localparam int CPM_POS_MIC_OVRD = 7;
    localparam int CPM_POS_OUT_WITH_IN = 6;
    localparam int CPM_POS_ADC_PD = 4;
    localparam int CPM_POS_DAC_PD = 2;
    localparam int CPM_POS_POWER_LIMITER_EN = 1;
    localparam int CPM_POS_AMP_EN = 0;
    localparam int CPM_POS_BIAS_PIN = 6;
    localparam int CPM_POS_CONV_PIN = 4;
    // ==========================================================
    // Pin source codes
    localparam logic [2:0] CPM_SRC_OFF = 3'h0;
    localparam logic [2:0] CPM_SRC_BIDIR_ONE = 3'h1;
    localparam logic [2:0] CPM_SRC_BIDIR_TWO = 3'h2;
    localparam logic [2:0] CPM_SRC_INPUT_ONLY = 3'h3;
    localparam logic [2:0] CPM_SRC_SERIAL_OUT = 3'h4;
    localparam logic [2:0] CPM_SRC_PRIMARY = 3'h5;
    // ==========================================================
    // Output-pin function codes
    localparam logic [3:0] CPM_OUTF_DISABLED = 4'h0;
    localparam logic [3:0] CPM_OUTF_INPUT = 4'h1;
    localparam logic [3:0] CPM_OUTF_PRI_DATA = 4'h5;
    localparam logic [3:0] CPM_OUTF_LOOPBACK = 4'hD;
    localparam logic [3:0] CPM_OUTF_RESERVED = 4'hF;
    localparam logic [3:0] CPM_RST_OUT_FUNC = CPM_OUTF_PRI_DATA;
    // ==========================================================
    // Synchronised pin vector layout
    localparam int CPM_PIN_BIDIR_ONE = 0;
    localparam int CPM_PIN_BIDIR_TWO = 1;
    localparam int CPM_PIN_INPUT_ONLY = 2;
    localparam int CPM_PIN_SERIAL_OUT = 3;
    localparam int CPM_PIN_PRI_DATA = 4;
    localparam int CPM_PIN_PRI_FSYNC = 5;
    localparam int CPM_PIN_PRI_BCLK = 6;
    localparam int CPM_PIN_MIC_CLK = 7;
    localparam int CPM_PIN_COUNT = 8;
    localparam int CPM_SYNC_STAGES = 2;
endpackage

// ===== cpm_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module cpm_sync #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ==========================================================
    // Stages
    // First stage feeds only the second; nothing else may look at it
    logic [WIDTH-1:0] meta;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ===== cpm_pin_mux.sv
// Codec interface configuration registers and pin routing
`timescale 1ns/100ps
// What this block does
// - Bit 7 of 0x11 enables primary serial data input, reset one.
// - Secondary frame sync source field 6-4; codes 4, 6, 7 reserved.
// - Secondary bit clock source field 3-1; codes 4, 6, 7 reserved.
// - Secondary first data source at 0x12 bits 7-5, serial pin code 4.
// - Secondary second data source at bits 4-2, same encoding.
// - 0x13 bit 7 picks analog or PDM for record channel 1.
// - 0x13 bit 6 picks analog or PDM for record channel 2.
// - Bit 5 swaps latch edges of channels 1 and 2.
// - Bit 4 swaps latch edges of channels 3 and 4.
// - Bits 3-2 pick the pin carrying channel 1/2 PDM data.
// - Bits 1-0 pick the pin carrying channel 3/4 PDM data.
// - 0x14 bit 7 replaces input-only pin by data input pin for PDM data only.
// - 0x14 bit 6 makes serial output pin also a data input.
// - Bits 5-4 pick ADC power-down pin, ORed with register control.
// - Bits 3-2 pick DAC power-down pin, ORed with register control.
// - 0x14 bit 1 assigns power-limit control to bidir pin one.
// - 0x14 bit 0 assigns amplifier control to bidir pin one.
// - 0x15 bits 7-6 pick the microphone bias enable pin.
// - 0x15 bits 5-4 pick the auxiliary conversion start pin.
// - Output-pin function selects serial pin role, reset primary data.
module cpm_pin_mux
    import cpm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic reg_wr_en_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [3:0] out_func_in,
    input wire logic serial_data_out_in,
    input wire logic bidir_pin_one_in,
    input wire logic bidir_pin_two_in,
    input wire logic input_only_pin_in,
    input wire logic serial_pin_in,
    output logic serial_pin_out,
    output logic serial_pin_oe_out,
    input wire logic primary_data_pin_in,
    input wire logic primary_fsync_pin_in,
    input wire logic primary_bclk_pin_in,
    input wire logic mic_bitstream_clock_in,
    input wire logic rec_ch1_analog_in,
    input wire logic rec_ch2_analog_in,
    input wire logic adc_register_power_down_in,
    input wire logic dac_register_power_down_in,
    output logic primary_data_out,
    output logic secondary_fsync_out,
    output logic secondary_bclk_out,
    output logic secondary_enable_out,
    output logic secondary_data1_out,
    output logic secondary_data2_out,
    output logic [3:0] pdm_data_out,
    output logic [3:0] pdm_valid_out,
    output logic rec_ch1_out,
    output logic rec_ch2_out,
    output logic adc_power_down_out,
    output logic dac_power_down_out,
    output logic power_limiter_out,
    output logic amplifier_control_out,
    output logic microphone_bias_enable_out,
    output logic aux_conversion_start_out
);
    // ==========================================================
    // Helper functions
    // Two-bit pin pick; zero select gives a quiet low level
    function automatic logic pick2(input logic [1:0] sel,
                                   input logic [2:0] pins);
        logic r;
        r = 1'b0;
        case (sel)
            2'h1: r = pins[0];
            2'h2: r = pins[1];
            2'h3: r = pins[2];
            default: r = 1'b0;
        endcase
        return r;
    endfunction
    // Three-bit source pick; reserved codes read low
    function automatic logic pick3(input logic [2:0] sel,
        input logic [2:0] pins, input logic ser, input logic pri);
        logic r;
        r = 1'b0;
        case (sel)
            CPM_SRC_BIDIR_ONE: r = pins[0];
            CPM_SRC_BIDIR_TWO: r = pins[1];
            CPM_SRC_INPUT_ONLY: r = pins[2];
            CPM_SRC_SERIAL_OUT: r = ser;
            CPM_SRC_PRIMARY: r = pri;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] masked(input logic [7:0] wd,
        input logic [7:0] m, input logic [7:0] rv);
        return (wd & m) | (rv & ~m);
    endfunction

    // ==========================================================
    // Configuration registers
    logic [7:0] cfg_two;
    logic [7:0] cfg_three;
    logic [7:0] cfg_four;
    logic [7:0] cfg_five;
    logic [7:0] cfg_six;
    wire wr_two = reg_wr_en_in && reg_addr_in == CPM_ADDR_CFG_TWO;
    wire wr_three = reg_wr_en_in && reg_addr_in == CPM_ADDR_CFG_THREE;
    wire wr_four = reg_wr_en_in && reg_addr_in == CPM_ADDR_CFG_FOUR;
    wire wr_five = reg_wr_en_in && reg_addr_in == CPM_ADDR_CFG_FIVE;
    wire wr_six = reg_wr_en_in && reg_addr_in == CPM_ADDR_CFG_SIX;

    // Reserved bits keep their reset value whatever is written
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_two <= CPM_RST_CFG_TWO;
            cfg_three <= CPM_RST_CFG_THREE;
            cfg_four <= CPM_RST_CFG_FOUR;
            cfg_five <= CPM_RST_CFG_FIVE;
            cfg_six <= CPM_RST_CFG_SIX;
        end else begin
            if (wr_two) begin
                cfg_two <= masked(reg_wdata_in, CPM_WMASK_CFG_TWO,
                                  CPM_RST_CFG_TWO);
            end
            if (wr_three) begin
                cfg_three <= masked(reg_wdata_in, CPM_WMASK_CFG_THREE,
                                    CPM_RST_CFG_THREE);
            end
            if (wr_four) begin
                cfg_four <= masked(reg_wdata_in, CPM_WMASK_CFG_FOUR,
                                   CPM_RST_CFG_FOUR);
            end
            if (wr_five) begin
                cfg_five <= masked(reg_wdata_in, CPM_WMASK_CFG_FIVE,
                                   CPM_RST_CFG_FIVE);
            end
            if (wr_six) begin
                cfg_six <= masked(reg_wdata_in, CPM_WMASK_CFG_SIX,
                                  CPM_RST_CFG_SIX);
            end
        end
    end

    // Unmapped offsets read zero
    always_comb begin
        case (reg_addr_in)
            CPM_ADDR_CFG_TWO: reg_rdata_out = cfg_two;
            CPM_ADDR_CFG_THREE: reg_rdata_out = cfg_three;
            CPM_ADDR_CFG_FOUR: reg_rdata_out = cfg_four;
            CPM_ADDR_CFG_FIVE: reg_rdata_out = cfg_five;
            CPM_ADDR_CFG_SIX: reg_rdata_out = cfg_six;
            default: reg_rdata_out = 8'h00;
        endcase
    end

    // ==========================================================
    // Field decode
    wire primary_serial_input_enable = cfg_two[CPM_POS_PRI_IN_EN];
    wire [2:0] secondary_frame_sync_source =
        cfg_two[CPM_POS_SEC_FSYNC +: 3];
    wire [2:0] secondary_bit_clock_source = cfg_two[CPM_POS_SEC_BCLK +: 3];
    wire [2:0] secondary_first_input_source =
        cfg_three[CPM_POS_SEC_IN1 +: 3];
    wire [2:0] secondary_second_input_source =
        cfg_three[CPM_POS_SEC_IN2 +: 3];
    wire record_ch1_digital_select = cfg_four[CPM_POS_REC1_DIG];
    wire record_ch2_digital_select = cfg_four[CPM_POS_REC2_DIG];
    wire pair_one_latch_edge = cfg_four[CPM_POS_PAIR1_EDGE];
    wire pair_two_latch_edge = cfg_four[CPM_POS_PAIR2_EDGE];
    wire [1:0] pair_one_data_pin = cfg_four[CPM_POS_PAIR1_PIN +: 2];
    wire [1:0] pair_two_data_pin = cfg_four[CPM_POS_PAIR2_PIN +: 2];
    wire mic_data_pin_override = cfg_five[CPM_POS_MIC_OVRD];
    wire out_with_in = cfg_five[CPM_POS_OUT_WITH_IN];
    wire [1:0] adc_powerdown_pin = cfg_five[CPM_POS_ADC_PD +: 2];
    wire [1:0] dac_powerdown_pin = cfg_five[CPM_POS_DAC_PD +: 2];
    wire power_limit_pin_enable = cfg_five[CPM_POS_POWER_LIMITER_EN];
    wire amp_control_pin_enable = cfg_five[CPM_POS_AMP_EN];
    wire [1:0] mic_bias_enable_pin = cfg_six[CPM_POS_BIAS_PIN +: 2];
    wire [1:0] aux_conversion_start_pin = cfg_six[CPM_POS_CONV_PIN +: 2];

    // ==========================================================
    // Pin synchronisers
    logic [CPM_PIN_COUNT-1:0] pins_raw;
    logic [CPM_PIN_COUNT-1:0] pins;
    assign pins_raw = {mic_bitstream_clock_in, primary_bclk_pin_in,
                       primary_fsync_pin_in, primary_data_pin_in,
                       serial_pin_in, input_only_pin_in,
                       bidir_pin_two_in, bidir_pin_one_in};

    cpm_sync #(
        .WIDTH(CPM_PIN_COUNT)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    wire [2:0] gp = pins[CPM_PIN_INPUT_ONLY:CPM_PIN_BIDIR_ONE];
    wire pri_data = pins[CPM_PIN_PRI_DATA];

    // ==========================================================
    // Serial output pin role
    wire outf_input = out_func_in == CPM_OUTF_INPUT;
    wire outf_quiet = out_func_in == CPM_OUTF_DISABLED ||
                      out_func_in == CPM_OUTF_RESERVED;
    wire ser_is_input = out_with_in || outf_input;
    wire ser_drives = !outf_input && !outf_quiet;
    wire ser_level = ser_is_input ? pins[CPM_PIN_SERIAL_OUT] : 1'b0;
    wire loop_sel = out_func_in == CPM_OUTF_LOOPBACK;
    wire next_ser_out = loop_sel ? pri_data : serial_data_out_in;

    // ==========================================================
    // Secondary port and primary input routing
    // Serial pin code is reserved for frame sync and bit clock: their slot is tied low
    wire next_sec_fsync = pick3(secondary_frame_sync_source, gp, 1'b0,
                                pins[CPM_PIN_PRI_FSYNC]);
    wire next_sec_bclk = pick3(secondary_bit_clock_source, gp, 1'b0,
                               pins[CPM_PIN_PRI_BCLK]);
    wire next_sec_data1 = pick3(secondary_first_input_source, gp,
                                ser_level, pri_data);
    wire next_sec_data2 = pick3(secondary_second_input_source, gp,
                                ser_level, pri_data);
    wire sec_fs_ok = secondary_frame_sync_source inside
                     {CPM_SRC_BIDIR_ONE, CPM_SRC_BIDIR_TWO,
                      CPM_SRC_INPUT_ONLY, CPM_SRC_PRIMARY};
    wire sec_bc_ok = secondary_bit_clock_source inside
                     {CPM_SRC_BIDIR_ONE, CPM_SRC_BIDIR_TWO,
                      CPM_SRC_INPUT_ONLY, CPM_SRC_PRIMARY};
    wire next_pri_data = primary_serial_input_enable & pri_data;

    // ==========================================================
    // Microphone data pins and latching edges
    // Override swaps the input-only pin for the data input pin
    wire [2:0] mic_pins = {mic_data_pin_override ? pri_data : gp[2],
                           gp[1], gp[0]};
    wire pair1_bit = pick2(pair_one_data_pin, mic_pins);
    wire pair2_bit = pick2(pair_two_data_pin, mic_pins);
    logic mic_clk_prev;
    wire mic_rise = pins[CPM_PIN_MIC_CLK] && !mic_clk_prev;
    wire mic_fall = !pins[CPM_PIN_MIC_CLK] && mic_clk_prev;
    // Edge bit zero: odd channel on falling edge, even on rising
    wire ch1_edge = pair_one_latch_edge ? mic_rise : mic_fall;
    wire ch2_edge = pair_one_latch_edge ? mic_fall : mic_rise;
    wire ch3_edge = pair_two_latch_edge ? mic_rise : mic_fall;
    wire ch4_edge = pair_two_latch_edge ? mic_fall : mic_rise;
    wire [3:0] lat_en = {ch4_edge && pair_two_data_pin != 2'h0,
                         ch3_edge && pair_two_data_pin != 2'h0,
                         ch2_edge && pair_one_data_pin != 2'h0,
                         ch1_edge && pair_one_data_pin != 2'h0};
    wire [3:0] lat_bits = {pair2_bit, pair2_bit, pair1_bit, pair1_bit};

    // ==========================================================
    // Control pin functions
    wire adc_pin_pd = pick2(adc_powerdown_pin, gp);
    wire dac_pin_pd = pick2(dac_powerdown_pin, gp);
    wire bias_level = pick2(mic_bias_enable_pin, gp);
    wire conv_level = pick2(aux_conversion_start_pin, gp);
    logic conv_prev;

    // ==========================================================
    // Output registers
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mic_clk_prev <= 1'b0;
            conv_prev <= 1'b0;
            pdm_data_out <= 4'h0;
            pdm_valid_out <= 4'h0;
            primary_data_out <= 1'b0;
            secondary_fsync_out <= 1'b0;
            secondary_bclk_out <= 1'b0;
            secondary_enable_out <= 1'b0;
            secondary_data1_out <= 1'b0;
            secondary_data2_out <= 1'b0;
            serial_pin_out <= 1'b0;
            serial_pin_oe_out <= 1'b0;
        end else begin
            mic_clk_prev <= pins[CPM_PIN_MIC_CLK];
            conv_prev <= conv_level;
            pdm_data_out <= (lat_en & lat_bits) |
                            (~lat_en & pdm_data_out);
            pdm_valid_out <= lat_en;
            primary_data_out <= next_pri_data;
            secondary_fsync_out <= next_sec_fsync;
            secondary_bclk_out <= next_sec_bclk;
            secondary_enable_out <= sec_fs_ok && sec_bc_ok;
            secondary_data1_out <= next_sec_data1;
            secondary_data2_out <= next_sec_data2;
            serial_pin_out <= next_ser_out;
            serial_pin_oe_out <= ser_drives;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rec_ch1_out <= 1'b0;
            rec_ch2_out <= 1'b0;
            adc_power_down_out <= 1'b0;
            dac_power_down_out <= 1'b0;
            power_limiter_out <= 1'b0;
            amplifier_control_out <= 1'b0;
            microphone_bias_enable_out <= 1'b0;
            aux_conversion_start_out <= 1'b0;
        end else begin
            rec_ch1_out <= record_ch1_digital_select ? pdm_data_out[0] :
                           rec_ch1_analog_in;
            rec_ch2_out <= record_ch2_digital_select ? pdm_data_out[1] :
                           rec_ch2_analog_in;
            adc_power_down_out <= adc_register_power_down_in |
                                  adc_pin_pd;
            dac_power_down_out <= dac_register_power_down_in |
                                  dac_pin_pd;
            power_limiter_out <= power_limit_pin_enable & gp[0];
            amplifier_control_out <= amp_control_pin_enable & gp[0];
            microphone_bias_enable_out <= bias_level;
            aux_conversion_start_out <= conv_level & ~conv_prev;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    pri_gate_a: assert property (
        !primary_serial_input_enable |=> !primary_data_out)
        else $error("primary data passed while disabled");
    fs_route_a: assert property (
        secondary_frame_sync_source == CPM_SRC_BIDIR_TWO &&
        $stable(secondary_frame_sync_source)
        |=> secondary_fsync_out == $past(gp[1]))
        else $error("frame sync not taken from bidir pin two");
    bc_off_a: assert property (
        secondary_bit_clock_source == CPM_SRC_OFF |=> !secondary_bclk_out)
        else $error("bit clock active while disabled");
    din1_ser_a: assert property (
        secondary_first_input_source == CPM_SRC_SERIAL_OUT && !ser_is_input
        |=> !secondary_data1_out)
        else $error("serial pin used while not an input");
    rec1_sel_a: assert property (
        !record_ch1_digital_select |=> rec_ch1_out == $past(rec_ch1_analog_in))
        else $error("record channel 1 analog path wrong");
    edge_one_a: assert property (
        !pair_one_latch_edge && pair_one_data_pin != 2'h0 && mic_fall
        |=> pdm_valid_out[0] && !pdm_valid_out[1])
        else $error("channel 1 not latched on falling edge");
    edge_two_a: assert property (
        pair_two_latch_edge && pair_two_data_pin != 2'h0 && mic_fall
        |=> pdm_valid_out[3] && !pdm_valid_out[2])
        else $error("channel 4 not latched on falling edge");
    adc_pd_a: assert property (
        adc_register_power_down_in |=> adc_power_down_out)
        else $error("register power down ignored");
    dac_pin_a: assert property (
        dac_powerdown_pin == 2'h0 && !dac_register_power_down_in
        |=> !dac_power_down_out)
        else $error("dac pin acted while select zero");
    resv_a: assert property (
        !cfg_two[0] && cfg_three[1:0] == 2'h0 && cfg_six[3:0] == 4'h0)
        else $error("reserved bits changed");
    conv_pulse_a: assert property (
        aux_conversion_start_out |=> !aux_conversion_start_out)
        else $error("conversion start longer than one cycle");

    pdm_seen_c: cover property (pdm_valid_out != 4'h0);
    sec_on_c: cover property (secondary_enable_out);
    ovrd_c: cover property (mic_data_pin_override &&
                            pair_one_data_pin == 2'h3 && pdm_valid_out[0]);
    conv_c: cover property (aux_conversion_start_out);
endmodule

// ===== cpm_mic_model.sv
// PDM microphone model for the pin-mux bench
`timescale 1ns/100ps
module cpm_mic_model (
    input wire logic sys_clk_in,
    input wire logic run_in,
    input wire logic left_in,
    input wire logic right_in,
    output logic mic_clk_out,
    output logic mic_dat_out
);
    // =====
    // Clock stands still between frames; four cycles a level
    logic [1:0] cnt = 2'h0;
    initial mic_clk_out = 1'b0;
    initial mic_dat_out = 1'b0;
    always @(posedge sys_clk_in) begin
        cnt <= run_in ? cnt + 2'h1 : 2'h0;
        if (run_in && cnt == 2'h3) begin
            mic_clk_out <= ~mic_clk_out;
        end
        // Data moves mid-level so it is steady at both clock edges
        if (run_in && cnt == 2'h1) begin
            mic_dat_out <= mic_clk_out ? left_in : right_in;
        end
    end
endmodule

// ===== tb_cpm_pin_mux.sv
// Self-checking bench for the codec pin-mux block
`timescale 1ns/100ps
module tb_cpm_pin_mux;
    import cpm_pkg::*;
    logic sys_clk_in = 1'b0, rstn_in = 1'b0, wr = 1'b0, run = 1'b0;
    logic [7:0] a = 8'h00, wd = 8'h00;
    logic [2:0] p = 3'h0;
    logic ser = 1'b0, pri = 1'b0, fs = 1'b0, bc = 1'b0, sdo = 1'b0;
    logic ra = 1'b0, adcr = 1'b0, dacr = 1'b0, mic = 1'b0, mc, md;
    logic lf = 1'b0, rt = 1'b0, o = 1'b0;
    logic [3:0] of = CPM_RST_OUT_FUNC;
    wire logic [7:0] rd;
    wire logic [23:0] mon;
    logic [13:0] q[$];
    logic [13:0] e;
    int seed = 32'h931C3588, err_total = 0, n_compared = 0;
    event look;
    always #2 sys_clk_in = ~sys_clk_in;
    cpm_mic_model u_cpm_mic_model (.sys_clk_in(sys_clk_in), .run_in(run),
        .left_in(lf), .right_in(rt), .mic_clk_out(mc), .mic_dat_out(md));
    cpm_pin_mux u_cpm_pin_mux (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .reg_wr_en_in(wr), .reg_addr_in(a), .reg_wdata_in(wd),
        .reg_rdata_out(rd), .out_func_in(of), .serial_data_out_in(sdo),
        .bidir_pin_one_in(p[0]), .bidir_pin_two_in(p[1]),
        .input_only_pin_in(mic ? md : p[2]), .serial_pin_in(ser),
        .serial_pin_out(mon[8]), .serial_pin_oe_out(mon[9]),
        .primary_data_pin_in(pri),
        .primary_fsync_pin_in(fs), .primary_bclk_pin_in(bc),
        .mic_bitstream_clock_in(mc), .rec_ch1_analog_in(ra),
        .rec_ch2_analog_in(ra), .adc_register_power_down_in(adcr),
        .dac_register_power_down_in(dacr), .primary_data_out(mon[0]),
        .secondary_fsync_out(mon[1]), .secondary_bclk_out(mon[2]),
        .secondary_enable_out(mon[10]), .secondary_data1_out(mon[3]),
        .secondary_data2_out(mon[11]), .pdm_data_out(mon[19:16]),
        .pdm_valid_out(mon[23:20]), .rec_ch1_out(mon[12]),
        .rec_ch2_out(mon[15]), .adc_power_down_out(mon[4]),
        .dac_power_down_out(mon[5]), .power_limiter_out(mon[6]),
        .amplifier_control_out(mon[13]),
        .microphone_bias_enable_out(mon[7]),
        .aux_conversion_start_out(mon[14]));
    // =====
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] x);
        n_compared++;
        if (seen !== x) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, x);
        end
    endtask
    task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
        @(negedge sys_clk_in);
        a = ad;
        wd = d;
        wr = 1'b1;
        @(negedge sys_clk_in);
        wr = 1'b0;
    endtask
    task automatic expb(input logic [4:0] s, input logic v);
        q.push_back({1'b0, s, 7'h00, v});
    endtask
    function automatic logic src(input logic [2:0] c, input logic x4,
        input logic x5);
        return c == 3'h4 ? x4 : c == 3'h5 ? x5 : c > 3'h5 ? 1'b0 : c == 3'h0
            ? 1'b0 : p[c - 3'h1];
    endfunction
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // =====
    // Result watcher: oldest note against the outputs
    always @(look) begin
        while (q.size() > 0) begin
            e = q.pop_front();
            check(e[13] ? rd : {7'h00, mon[e[12:8]]}, e[7:0]);
        end
    end
    // =====
    // Stimulus
    initial begin
        repeat (16) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rstn_in = 1'b1;
        for (int i = 16; i < 23; i++) begin
            @(negedge sys_clk_in);
            a = i[7:0];
            q.push_back({6'h20, i == 17 ? 8'h80 : 8'h00});
            #1 -> look;
        end
        $display("reset values done");
        for (int i = 17; i < 22; i++) begin
            wreg(i[7:0], 8'hFF);
            q.push_back({6'h20, i == 17 ? 8'hFE : i == 18 ? 8'hFC :
                i == 21 ? 8'hF0 : 8'hFF});
            #1 -> look;
        end
        $display("access masks done");
        for (int c = 0; c < 8; c++) begin
            wreg(8'h11, {c[0], c[2:0], c[2:0], 1'b0});
            wreg(8'h12, {c[2:0], c[2:0], 2'h0});
            {p, ser, pri, fs, bc} = 7'($random(seed));
            repeat (4) @(negedge sys_clk_in);
            expb(0, pri & c[0]);
            expb(1, src(c[2:0], 1'b0, fs));
            expb(2, src(c[2:0], 1'b0, bc));
            expb(3, src(c[2:0], ser, pri));
            expb(11, src(c[2:0], ser, pri));
            expb(10, c > 0 && c != 4 && c < 6);
            #1 -> look;
        end
        $display("serial routing done");
        for (int c = 0; c < 4; c++) begin
            wreg(8'h14, {2'h0, c[1:0], c[1:0], c[0], !c[0]});
            wreg(8'h15, {c[1:0], c[1:0], 4'h0});
            o = src({1'b0, c[1:0]}, 1'b0, 1'b0);
            of = c == 0 ? CPM_OUTF_PRI_DATA : c == 1 ? CPM_OUTF_LOOPBACK :
                c == 2 ? CPM_OUTF_INPUT : CPM_OUTF_RESERVED;
            {p, adcr, dacr, ra, sdo} = 7'($random(seed));
            // Start pulse stands one cycle, three edges after the pin
            repeat (3) @(negedge sys_clk_in);
            expb(14, src({1'b0, c[1:0]}, 1'b0, 1'b0) & !o);
            #1 -> look;
            @(negedge sys_clk_in);
            expb(4, adcr | src({1'b0, c[1:0]}, 1'b0, 1'b0));
            expb(5, dacr | src({1'b0, c[1:0]}, 1'b0, 1'b0));
            expb(6, c[0] & p[0]);
            expb(13, !c[0] & p[0]);
            expb(7, src({1'b0, c[1:0]}, 1'b0, 1'b0));
            expb(8, c == 1 ? pri : sdo);
            expb(9, c < 2);
            #1 -> look;
        end
        $display("control pins done");
        mic = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wreg(8'h13, {k[0], !k[0], k[0], k[0], 4'hF});
            {lf, rt, ra} = 3'($random(seed));
            run = 1'b1;
            repeat (200) @(negedge sys_clk_in);
            run = 1'b0;
            repeat (8) @(negedge sys_clk_in);
            expb(16, k ? rt : lf);
            expb(17, k ? lf : rt);
            expb(18, k ? rt : lf);
            expb(19, k ? lf : rt);
            expb(12, k ? rt : ra);
            expb(15, k ? ra : rt);
            for (int j = 20; j < 24; j++) begin
                expb(j[4:0], 1'b0);
            end
            #1 -> look;
        end
        $display("pdm paths done");
        #10;
        summarize();
    end
endmodule
